/* File: core_power_retention_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "core_power_retention_map.svh"
module core_power_retention_control (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // system register access
  input wire logic ACCESS_VALID_IN,
  input wire logic ACCESS_WRITE_IN,
  input wire core_power_retention_pkg::exc_level_type ACCESS_LEVEL_IN,
  input wire logic [63:0] WRITE_DATA_IN,
  output logic ACCESS_DONE_OUT,
  output logic [63:0] READ_DATA_OUT,
  output logic ACCESS_UNDEF_OUT,
  output logic ACCESS_TRAP_EL2_OUT,
  output logic ACCESS_TRAP_EL3_OUT,
  output logic [5:0] TRAP_CLASS_OUT,
  // access gating state
  input wire logic LEVEL2_ENABLED_IN,
  input wire logic IMPDEF_REGISTER_TRAP_IN,
  input wire logic CORE_HALTED_IN,
  input wire logic SECURE_DEBUG_DISABLE_IN,
  input wire logic LEVEL2_POWER_WRITE_ENABLE_IN,
  input wire logic LEVEL3_POWER_WRITE_ENABLE_IN,
  // core state and system counter
  input wire logic SYSTEM_COUNTER_TICK_IN,
  input wire logic VECTOR_UNIT_IDLE_IN,
  input wire logic WAIT_FOR_EVENT_STATE_IN,
  input wire logic WAIT_FOR_INTERRUPT_STATE_IN,
  // power controls
  output logic VECTOR_UNIT_POWERDOWN_OUT,
  output logic RETENTION_ENTRY_OUT,
  output logic CORE_POWERDOWN_REQUEST_OUT
);
  import core_power_retention_pkg::*;

  logic [12:0] ctrl_q;
  logic [12:0] ctrl_d;
  logic done_q;
  logic done_d;
  logic [63:0] rdata_q;
  logic [63:0] rdata_d;
  logic undef_q;
  logic undef_d;
  logic trap2_q;
  logic trap2_d;
  logic trap3_q;
  logic trap3_d;
  access_result_type result;
  logic halted_sdd;
  logic vu_expired;
  logic ew_expired;
  logic iw_expired;

  // outcome of one access; level0 first, then per-level trap order
  always_comb begin
    halted_sdd = CORE_HALTED_IN && SECURE_DEBUG_DISABLE_IN;
    result = RESULT_OK;
    case (ACCESS_LEVEL_IN)
      EL_0: begin
        result = RESULT_UNDEF;
      end
      EL_1: begin
        if (LEVEL2_ENABLED_IN && IMPDEF_REGISTER_TRAP_IN) begin
          result = RESULT_TRAP_EL2;
        end else if (!ACCESS_WRITE_IN) begin
          result = RESULT_OK;
        end else if (halted_sdd && !LEVEL3_POWER_WRITE_ENABLE_IN) begin
          result = RESULT_UNDEF;
        end else if (LEVEL2_ENABLED_IN && !LEVEL2_POWER_WRITE_ENABLE_IN) begin
          result = RESULT_TRAP_EL2;
        end else if (!LEVEL3_POWER_WRITE_ENABLE_IN) begin
          result = RESULT_TRAP_EL3;
        end
      end
      EL_2: begin
        if (!ACCESS_WRITE_IN) begin
          result = RESULT_OK;
        end else if (!LEVEL3_POWER_WRITE_ENABLE_IN) begin
          result = halted_sdd ? RESULT_UNDEF : RESULT_TRAP_EL3;
        end
      end
      EL_3: begin
        result = RESULT_OK;
      end
      default: begin
        result = RESULT_UNDEF;
      end
    endcase
  end

  always_comb begin
    ctrl_d = ctrl_q;
    done_d = ACCESS_VALID_IN;
    rdata_d = rdata_q;
    undef_d = 1'b0;
    trap2_d = 1'b0;
    trap3_d = 1'b0;
    if (ACCESS_VALID_IN) begin
      undef_d = (result == RESULT_UNDEF);
      trap2_d = (result == RESULT_TRAP_EL2);
      trap3_d = (result == RESULT_TRAP_EL3);
      if (result == RESULT_OK && ACCESS_WRITE_IN) begin
        ctrl_d = {WRITE_DATA_IN[`VU_DELAY_HI:`IW_DELAY_LO], 3'h0,
                  WRITE_DATA_IN[`PWRDN_REQ_BIT]};
      end
      // a refused read leaves the old data; software sees only the fault
      if (result == RESULT_OK && !ACCESS_WRITE_IN) begin
        rdata_d = {51'h0, ctrl_q};
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ctrl_q <= `CTRL_RESET_VALUE;
      done_q <= 1'b0;
      rdata_q <= 64'h0;
      undef_q <= 1'b0;
      trap2_q <= 1'b0;
      trap3_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
      undef_q <= undef_d;
      trap2_q <= trap2_d;
      trap3_q <= trap3_d;
    end
  end

  tick_delay_timer vu_timer (
    .clk_in(CLK_IN),
    .reset_in(RESET_IN),
    .code_in(ctrl_q[`VU_DELAY_HI:`VU_DELAY_LO]),
    .active_in(VECTOR_UNIT_IDLE_IN),
    .tick_in(SYSTEM_COUNTER_TICK_IN),
    .expired_out(vu_expired)
  );

  tick_delay_timer ew_timer (
    .clk_in(CLK_IN),
    .reset_in(RESET_IN),
    .code_in(ctrl_q[`EW_DELAY_HI:`EW_DELAY_LO]),
    .active_in(WAIT_FOR_EVENT_STATE_IN),
    .tick_in(SYSTEM_COUNTER_TICK_IN),
    .expired_out(ew_expired)
  );

  tick_delay_timer iw_timer (
    .clk_in(CLK_IN),
    .reset_in(RESET_IN),
    .code_in(ctrl_q[`IW_DELAY_HI:`IW_DELAY_LO]),
    .active_in(WAIT_FOR_INTERRUPT_STATE_IN),
    .tick_in(SYSTEM_COUNTER_TICK_IN),
    .expired_out(iw_expired)
  );

  assign ACCESS_DONE_OUT = done_q;
  assign READ_DATA_OUT = rdata_q;
  assign ACCESS_UNDEF_OUT = undef_q;
  assign ACCESS_TRAP_EL2_OUT = trap2_q;
  assign ACCESS_TRAP_EL3_OUT = trap3_q;
  assign TRAP_CLASS_OUT = (trap2_q || trap3_q) ? `TRAP_CLASS : 6'h00;
  assign VECTOR_UNIT_POWERDOWN_OUT = vu_expired;
  assign RETENTION_ENTRY_OUT = ew_expired || iw_expired;
  assign CORE_POWERDOWN_REQUEST_OUT = ctrl_q[`PWRDN_REQ_BIT];

  AST_LEVEL0_UNDEF: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    ACCESS_VALID_IN && ACCESS_LEVEL_IN == EL_0 |=> ACCESS_UNDEF_OUT && $stable(ctrl_q))
    else $error("level0 access not undefined");
  AST_LEVEL3_WRITES: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    ACCESS_VALID_IN && ACCESS_WRITE_IN && ACCESS_LEVEL_IN == EL_3
    |=> ctrl_q[`PWRDN_REQ_BIT] == $past(WRITE_DATA_IN[`PWRDN_REQ_BIT]) && !ACCESS_UNDEF_OUT)
    else $error("level3 write lost");
  AST_EL1_READ_TRAP: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    ACCESS_VALID_IN && !ACCESS_WRITE_IN && ACCESS_LEVEL_IN == EL_1 && LEVEL2_ENABLED_IN
    && IMPDEF_REGISTER_TRAP_IN |=> ACCESS_TRAP_EL2_OUT && TRAP_CLASS_OUT == `TRAP_CLASS)
    else $error("level1 read not trapped");
  AST_EL1_WRITE_L2: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    ACCESS_VALID_IN && ACCESS_WRITE_IN && ACCESS_LEVEL_IN == EL_1 && LEVEL2_ENABLED_IN
    && !IMPDEF_REGISTER_TRAP_IN && !CORE_HALTED_IN && !LEVEL2_POWER_WRITE_ENABLE_IN
    |=> ACCESS_TRAP_EL2_OUT && $stable(ctrl_q))
    else $error("level1 write not trapped to level2");
  AST_EL2_WRITE_L3: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    ACCESS_VALID_IN && ACCESS_WRITE_IN && ACCESS_LEVEL_IN == EL_2
    && !LEVEL3_POWER_WRITE_ENABLE_IN && !CORE_HALTED_IN |=> ACCESS_TRAP_EL3_OUT)
    else $error("level2 write not trapped to level3");
  AST_RESERVED_ZERO: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    ACCESS_DONE_OUT |-> READ_DATA_OUT[63:13] == 51'h0 && READ_DATA_OUT[3:1] == 3'h0)
    else $error("reserved bits nonzero");
  AST_RET_DISABLED: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    ctrl_q[`EW_DELAY_HI:`EW_DELAY_LO] == 3'h0 && ctrl_q[`IW_DELAY_HI:`IW_DELAY_LO] == 3'h0
    && $past(ctrl_q[9:4]) == 6'h0 |-> !RETENTION_ENTRY_OUT)
    else $error("retention with delays disabled");
  AST_VU_DISABLED: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    ctrl_q[`VU_DELAY_HI:`VU_DELAY_LO] == 3'h0 && $past(ctrl_q[12:10]) == 3'h0
    |-> !VECTOR_UNIT_POWERDOWN_OUT)
    else $error("vector unit powered down while disabled");
  // interrupt wait with the shortest delay and event-wait retention off
  logic iw_two_tick_mode;
  assign iw_two_tick_mode = ctrl_q[`IW_DELAY_HI:`IW_DELAY_LO] == 3'h1
    && ctrl_q[`EW_DELAY_HI:`EW_DELAY_LO] == 3'h0 && WAIT_FOR_INTERRUPT_STATE_IN;
  // ticks arrive sparsely, so the second tick follows three quiet cycles
  AST_IW_TWO_TICKS: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    iw_two_tick_mode && SYSTEM_COUNTER_TICK_IN && !RETENTION_ENTRY_OUT
    ##1 (iw_two_tick_mode && !SYSTEM_COUNTER_TICK_IN)[*3]
    ##1 (iw_two_tick_mode && SYSTEM_COUNTER_TICK_IN)
    |=> RETENTION_ENTRY_OUT)
    else $error("two-tick retention missed");
  AST_PWRDN_REQ: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    $changed(CORE_POWERDOWN_REQUEST_OUT) |-> $past(ACCESS_VALID_IN && ACCESS_WRITE_IN)
    && ACCESS_DONE_OUT && !ACCESS_UNDEF_OUT && !ACCESS_TRAP_EL2_OUT && !ACCESS_TRAP_EL3_OUT)
    else $error("powerdown request moved without a write");

  COV_EL3_WRITE: cover property (@(posedge CLK_IN) disable iff (RESET_IN)
    ACCESS_VALID_IN && ACCESS_WRITE_IN && ACCESS_LEVEL_IN == EL_3);
  COV_TRAP3: cover property (@(posedge CLK_IN) disable iff (RESET_IN) ACCESS_TRAP_EL3_OUT);
  COV_RETENTION: cover property (@(posedge CLK_IN) disable iff (RESET_IN) RETENTION_ENTRY_OUT);
  COV_VU_DOWN: cover property (@(posedge CLK_IN) disable iff (RESET_IN)
    VECTOR_UNIT_POWERDOWN_OUT);
endmodule : core_power_retention_control
`default_nettype wire

/* File: core_power_retention_map.svh */
`ifndef CORE_POWER_RETENTION_MAP_SVH
`define CORE_POWER_RETENTION_MAP_SVH
`define VU_DELAY_HI 12
`define VU_DELAY_LO 10
`define EW_DELAY_HI 9
`define EW_DELAY_LO 7
`define IW_DELAY_HI 6
`define IW_DELAY_LO 4
`define PWRDN_REQ_BIT 0
`define CTRL_RESET_VALUE 13'h0000
`define TRAP_CLASS 6'h18
`define TICKS_CODE1 10'h002
`define TICKS_CODE2 10'h008
`define TICKS_CODE3 10'h020
`define TICKS_CODE4 10'h040
`define TICKS_CODE5 10'h080
`define TICKS_CODE6 10'h100
`define TICKS_CODE7 10'h200
`endif

/* File: core_power_retention_pkg.sv */
package core_power_retention_pkg;
  typedef enum logic [1:0] {
    EL_0 = 2'h0,
    EL_1 = 2'h1,
    EL_2 = 2'h2,
    EL_3 = 2'h3
  } exc_level_type;
  typedef enum logic [3:0] {
    RESULT_OK = 4'h1,
    RESULT_UNDEF = 4'h2,
    RESULT_TRAP_EL2 = 4'h4,
    RESULT_TRAP_EL3 = 4'h8
  } access_result_type;
endpackage : core_power_retention_pkg

/* File: counter_tick_model.sv */
`timescale 1ns/1ps
`default_nettype none
module counter_tick_model #(parameter int PERIOD = 4) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // core side
  input wire logic request_in,
  input wire logic wait_in,
  // far side
  output logic tick_out,
  output logic core_off_out
);
  logic [7:0] cnt_q;
  // sparse ticks let the bench follow every count exactly
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_q <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
      tick_out <= (cnt_q == 8'(PERIOD - 1));
    end
  end
  assign core_off_out = request_in & wait_in;
endmodule : counter_tick_model
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "core_power_retention_map.svh"
module tb;
  import core_power_retention_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vld = 1'b0;
  logic wr = 1'b0;
  exc_level_type lvl = EL_0;
  logic [63:0] wd = 64'h0;
  logic l2on = 1'b0, trp = 1'b0, hlt = 1'b0, secure_debug_disable = 1'b0, l2pw = 1'b0, l3pw = 1'b0;
  logic vi = 1'b0, ew = 1'b0, iw = 1'b0;
  logic tick, done, und, t2, t3, vpd, ret, req, off;
  logic [63:0] rdat;
  logic [5:0] cls;
  int error_cnt = 0;
  int checks = 0;
  int tk[8] = '{3, 2, 8, 32, 64, 128, 256, 512};

  always #5 clk = ~clk;

  core_power_retention_control i_core_power_retention_control (
    .CLK_IN(clk), .RESET_IN(rst), .ACCESS_VALID_IN(vld), .ACCESS_WRITE_IN(wr),
    .ACCESS_LEVEL_IN(lvl), .WRITE_DATA_IN(wd), .ACCESS_DONE_OUT(done),
    .READ_DATA_OUT(rdat), .ACCESS_UNDEF_OUT(und), .ACCESS_TRAP_EL2_OUT(t2),
    .ACCESS_TRAP_EL3_OUT(t3), .TRAP_CLASS_OUT(cls), .LEVEL2_ENABLED_IN(l2on),
    .IMPDEF_REGISTER_TRAP_IN(trp), .CORE_HALTED_IN(hlt), .SECURE_DEBUG_DISABLE_IN(secure_debug_disable),
    .LEVEL2_POWER_WRITE_ENABLE_IN(l2pw), .LEVEL3_POWER_WRITE_ENABLE_IN(l3pw),
    .SYSTEM_COUNTER_TICK_IN(tick), .VECTOR_UNIT_IDLE_IN(vi),
    .WAIT_FOR_EVENT_STATE_IN(ew), .WAIT_FOR_INTERRUPT_STATE_IN(iw),
    .VECTOR_UNIT_POWERDOWN_OUT(vpd), .RETENTION_ENTRY_OUT(ret),
    .CORE_POWERDOWN_REQUEST_OUT(req));

  counter_tick_model i_counter_tick_model (
    .clk_in(clk), .reset_in(rst), .request_in(req), .wait_in(ew | iw),
    .tick_out(tick), .core_off_out(off));

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // g = {level2 on, trap bit, halted, secure debug off, level2 enable, level3 enable}
  task automatic acc(input logic we, input exc_level_type lv, input logic [63:0] d,
                     input logic [5:0] g, input logic [3:0] ex);
    @(negedge clk);
    {l2on, trp, hlt, secure_debug_disable, l2pw, l3pw} = g;
    vld = 1'b1;
    wr = we;
    lvl = lv;
    wd = d;
    @(negedge clk);
    vld = 1'b0;
    cmp(64'({t3, t2, und, done}), 64'(ex | 4'h1));
    cmp(64'(cls), (ex[3] | ex[2]) ? 64'(`TRAP_CLASS) : 64'h0);
  endtask : acc

  task automatic rd(input exc_level_type lv, input logic [5:0] g, input logic [63:0] exp);
    acc(1'b0, lv, 64'h0, g, RESULT_OK);
    cmp(rdat, exp);
  endtask : rd

  task automatic access_rules();
    logic [63:0] ff;
    ff = '1;
    acc(1'b1, EL_3, 64'h1491, 6'h00, RESULT_OK);
    acc(1'b0, EL_0, 64'h0, 6'h3f, RESULT_UNDEF);
    acc(1'b1, EL_0, ff, 6'h3f, RESULT_UNDEF);
    acc(1'b0, EL_1, 64'h0, 6'h30, RESULT_TRAP_EL2);
    acc(1'b1, EL_1, ff, 6'h33, RESULT_TRAP_EL2);
    acc(1'b1, EL_1, ff, 6'h2e, RESULT_UNDEF);
    acc(1'b1, EL_1, ff, 6'h21, RESULT_TRAP_EL2);
    acc(1'b1, EL_1, ff, 6'h06, RESULT_TRAP_EL3);
    acc(1'b1, EL_2, ff, 6'h0c, RESULT_UNDEF);
    acc(1'b1, EL_2, ff, 6'h14, RESULT_TRAP_EL3);
    rd(EL_2, 6'h30, 64'h1491);
    rd(EL_1, 6'h10, 64'h1491);
    acc(1'b1, EL_1, ff, 6'h23, RESULT_OK);
    rd(EL_3, 6'h00, 64'h1ff1);
    cmp(64'(req), 64'h1);
    @(negedge clk);
    ew = 1'b1;
    #1 cmp(64'(off), 64'h1);
    @(negedge clk);
    ew = 1'b0;
    #1 cmp(64'(off), 64'h0);
    acc(1'b1, EL_2, 64'h0, 6'h0d, RESULT_OK);
    rd(EL_3, 6'h00, 64'h0);
    cmp(64'(req), 64'h0);
  endtask : access_rules

  // st = {vector idle, event wait, interrupt wait}
  task automatic timer(input int sh, input logic [2:0] st);
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, EL_3, 64'(c) << sh, 6'h00, RESULT_OK);
      do @(posedge clk); while (tick !== 1'b1);
      @(negedge clk);
      {vi, ew, iw} = st;
      for (int k = 1; k < tk[c]; k++) begin
        do @(posedge clk); while (tick !== 1'b1);
      end
      @(negedge clk);
      cmp(64'(st[2] ? vpd : ret), 64'h0);
      do @(posedge clk); while (tick !== 1'b1);
      repeat (2) @(negedge clk);
      cmp(64'(st[2] ? vpd : ret), 64'(c != 0));
      {vi, ew, iw} = 3'b000;
      repeat (2) @(negedge clk);
      cmp(64'(st[2] ? vpd : ret), 64'h0);
    end
  endtask : timer

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    access_rules();
    timer(10, 3'b100);
    timer(7, 3'b010);
    timer(4, 3'b001);
    wrap_up();
  end

  // a hang costs far more than the whole run of about 123 us
  initial begin
    #400000;
    error_cnt++;
    wrap_up();
  end
endmodule : tb
`default_nettype wire

/* File: tick_delay_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "core_power_retention_map.svh"
module tick_delay_timer (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [2:0] code_in,
  input wire logic active_in,
  input wire logic tick_in,
  output logic expired_out
);
  logic [9:0] count_q;
  logic [9:0] count_d;
  logic expired_q;
  logic expired_d;
  logic [9:0] target;

  function automatic logic [9:0] ticks_for(input logic [2:0] code);
    case (code)
      3'h1: ticks_for = `TICKS_CODE1;
      3'h2: ticks_for = `TICKS_CODE2;
      3'h3: ticks_for = `TICKS_CODE3;
      3'h4: ticks_for = `TICKS_CODE4;
      3'h5: ticks_for = `TICKS_CODE5;
      3'h6: ticks_for = `TICKS_CODE6;
      3'h7: ticks_for = `TICKS_CODE7;
      default: ticks_for = 10'h000;
    endcase
  endfunction : ticks_for

  always_comb begin
    target = ticks_for(code_in);
    count_d = count_q;
    expired_d = expired_q;
    // code zero disables, leaving the state live forever
    if (!active_in || code_in == 3'h0) begin
      count_d = 10'h000;
      expired_d = 1'b0;
    end else if (tick_in && !expired_q) begin
      count_d = count_q + 10'h001;
      if (count_q + 10'h001 >= target) begin
        expired_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_q <= 10'h000;
      expired_q <= 1'b0;
    end else begin
      count_q <= count_d;
      expired_q <= expired_d;
    end
  end

  assign expired_out = expired_q;
endmodule : tick_delay_timer
`default_nettype wire
